// ==== burned_in_address_reader.v ====
// Burned-in node address store, serial address generator and initialization reader.
//
// Notes on behaviour
// - The store supplies a 48-bit node address when joining gives none.
// - Byte 0 bits 0 and 1 must read 01, else joining fails with address error.
// - Circuit is an 8-bit serial-in shift register plus a 512 by 4 store.
// - Address and validation bits live in the second column, sent to the handler.
// - Third and fourth columns are unused and hold ones everywhere.
// - First column feeds the shift register input, forming seven low address bits.
// - Insert control low confines addressing to the lower 256 words, no address bits.
// - Insert control low with wire fault low returns zero to the handler.
// - Insert control low with wire fault high returns high; fault passes through.
// - Every initialization reads the burned-in address out of the store.
// - A zero join address selects the burned-in address as station address.
// - Every initialization tests circuit presence by trying to read the store.
// - Only the validation coding and byte 0 bits 0 and 1 are checked, never the rest of the address.
// - A faulty stored address ends the join with a node address error.
// - Reading runs with insert control high, reaching only the upper 256 words.
// - Address and validation code are stored identically in both upper halves.
// - The processor gets the address bits through the handler's fault input.
// - Address bits are stored complemented because the handler's input inverts.
`timescale 1ns/100ps
`include "burned_in_address_reader_map.vh"
module burned_in_address_reader #(
    parameter [47:0] BIA_VALUE  = 48'h400000000001,
    parameter [15:0] VALID_CODE = 16'hA55A,
    parameter        FIFO_DEPTH = 8
) (
    input  wire        ref_clk,
    input  wire        reset,
    input  wire        clk_en,
    input  wire        ring_insert_control,
    input  wire        wire_fault_line,
    input  wire        handler_shift_clk,
    output wire        fault_to_handler,
    input  wire        init_start,
    output wire        init_busy,
    output wire        init_done,
    output wire        circuit_present,
    output wire        address_ok,
    output wire [47:0] burned_in_node_address,
    output wire        byte_valid,
    input  wire        byte_ready,
    output wire [7:0]  byte_data,
    input  wire        join_req,
    input  wire [47:0] join_addr,
    output wire        join_done,
    output wire        join_error,
    output wire [47:0] station_addr
);

    ////////////////////////////////////////////////////////////////////////////////
    // Reader states.

    localparam [2:0] ST_IDLE   = 3'h0;
    localparam [2:0] ST_CLEAR  = 3'h1;
    localparam [2:0] ST_SAMPLE = 3'h2;
    localparam [2:0] ST_SHIFT  = 3'h3;
    localparam [2:0] ST_CHECK  = 3'h4;

    ////////////////////////////////////////////////////////////////////////////////
    // Declarations.

    reg  [1:0]  insert_sync_r;
    reg  [1:0]  fault_sync_r;
    reg  [2:0]  shclk_sync_r;
    reg  [7:0]  shreg_r;
    reg  [7:0]  shreg_nxt;
    reg         fault_out_r;
    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [6:0]  bit_cnt_r;
    reg  [6:0]  bit_cnt_nxt;
    reg  [47:0] addr_acc_r;
    reg  [47:0] addr_acc_nxt;
    reg  [15:0] code_acc_r;
    reg  [15:0] code_acc_nxt;
    reg  [7:0]  byte_acc_r;
    reg  [7:0]  byte_acc_nxt;
    reg         push_r;
    reg         push_nxt;
    reg  [7:0]  push_data_r;
    reg  [7:0]  push_data_nxt;
    reg         aborted_r;
    reg         aborted_nxt;
    reg         present_r;
    reg         present_nxt;
    reg         addr_ok_r;
    reg         addr_ok_nxt;
    reg         done_r;
    reg         done_nxt;
    reg  [47:0] bia_r;
    reg  [47:0] bia_nxt;
    reg         join_done_r;
    reg         join_err_r;
    reg  [47:0] station_r;
    wire [8:0]  store_addr;
    wire [3:0]  store_word;
    wire        address_column;
    wire        feedback_column;
    wire        handler_shift;
    wire        reader_shift;
    wire        fifo_in_ready;
    wire        serial_bit;

    ////////////////////////////////////////////////////////////////////////////////
    // Store contents, built at elaboration from the parameters.

    // Next serial input of the shift register for a given low address.
    function feedback_bit;
        input [6:0] a;
        begin
            feedback_bit = ~(a[6] ^ a[5]);
        end
    endfunction

    // Position of a low address along the walk that starts from a cleared register.
    function [6:0] step_of;
        input [6:0] a;
        integer     i;
        reg   [6:0] s;
        reg   [6:0] r;
        begin
            r = 7'h7F;
            s = 7'h00;
            for (i = 0; i < `BIA_SEQ_LEN; i = i + 1) begin
                if (s == a)
                    r = i[6:0];
                s = {s[5:0], feedback_bit(s)};
            end
            step_of = r;
        end
    endfunction

    function [3:0] prom_word;
        input [8:0] a;
        integer     st;
        reg         col;
        begin
            col = 1'b1;
            st  = 0;
            if (!a[`BIA_A_INSERT]) begin
                // Lower bank: address column mirrors the wire fault line.
                prom_word = {1'b1, 1'b1, a[`BIA_A_FAULT], 1'b1};
            end else begin
                // Upper bank ignores the wire fault line, so both halves agree.
                st = {25'h0000000, step_of(a[6:0])};
                if (st < `BIA_ADDR_BITS)
                    col = ~BIA_VALUE[`BIA_ADDR_BITS-1-st];
                else if (st < `BIA_READ_BITS)
                    col = ~VALID_CODE[`BIA_READ_BITS-1-st];
                prom_word = {1'b1, 1'b1, col, feedback_bit(a[6:0])};
            end
        end
    endfunction

    wire [3:0] prom_mem [0:`BIA_STORE_DEPTH-1];

    genvar g;
    generate
        for (g = 0; g < `BIA_STORE_DEPTH; g = g + 1) begin : rom_fill
            localparam [8:0] WORD_ADDR = g;
            assign prom_mem[g] = prom_word(WORD_ADDR);
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Pin synchronisers.

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            insert_sync_r <= 2'h0;
            fault_sync_r  <= 2'h0;
            shclk_sync_r  <= 3'h0;
        end else if (clk_en) begin
            insert_sync_r <= {insert_sync_r[0], ring_insert_control};
            fault_sync_r  <= {fault_sync_r[0], wire_fault_line};
            shclk_sync_r  <= {shclk_sync_r[1:0], handler_shift_clk};
        end
    end

    // Rising edge of the handler's shift clock advances the register one place.
    assign handler_shift = shclk_sync_r[1] & ~shclk_sync_r[2];

    ////////////////////////////////////////////////////////////////////////////////
    // Store addressing and the column returned to the handler.

    assign store_addr      = {insert_sync_r[1], fault_sync_r[1], shreg_r[6:0]};
    assign store_word      = prom_mem[store_addr];
    assign address_column  = store_word[`BIA_COL_ADDRESS];
    assign feedback_column = store_word[`BIA_COL_FEEDBACK];
    assign serial_bit      = ~address_column;

    always @* begin
        shreg_nxt = shreg_r;
        if (state_r == ST_CLEAR)
            shreg_nxt = 8'h00;
        else if (handler_shift || reader_shift)
            shreg_nxt = {shreg_r[6:0], feedback_column};
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            shreg_r     <= 8'h00;
            fault_out_r <= 1'b0;
        end else if (clk_en) begin
            shreg_r     <= shreg_nxt;
            fault_out_r <= address_column;
        end
    end

    assign fault_to_handler = fault_out_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Initialization reader: clears the register, then samples and shifts 64 times.

    assign reader_shift = (state_r == ST_SHIFT);

    always @* begin
        state_nxt     = state_r;
        bit_cnt_nxt   = bit_cnt_r;
        addr_acc_nxt  = addr_acc_r;
        code_acc_nxt  = code_acc_r;
        byte_acc_nxt  = byte_acc_r;
        push_nxt      = push_r;
        push_data_nxt = push_data_r;
        aborted_nxt   = aborted_r;
        present_nxt   = present_r;
        addr_ok_nxt   = addr_ok_r;
        done_nxt      = done_r;
        bia_nxt       = bia_r;
        if (push_r && fifo_in_ready)
            push_nxt = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (init_start) begin
                    state_nxt   = ST_CLEAR;
                    bit_cnt_nxt = 7'h00;
                    aborted_nxt = 1'b0;
                    present_nxt = 1'b0;
                    addr_ok_nxt = 1'b0;
                    done_nxt    = 1'b0;
                end
            end
            ST_CLEAR: begin
                state_nxt = ST_SAMPLE;
            end
            ST_SAMPLE: begin
                if (!insert_sync_r[1]) begin
                    // Inserted mid-read: the upper bank is out of reach.
                    aborted_nxt = 1'b1;
                    state_nxt   = ST_CHECK;
                end else if (!push_r || fifo_in_ready) begin
                    if (bit_cnt_r < `BIA_ADDR_BITS) begin
                        addr_acc_nxt = {addr_acc_r[46:0], serial_bit};
                        byte_acc_nxt = {byte_acc_r[6:0], serial_bit};
                        if (bit_cnt_r[2:0] == 3'h7) begin
                            push_nxt      = 1'b1;
                            push_data_nxt = {byte_acc_r[6:0], serial_bit};
                        end
                    end else begin
                        code_acc_nxt = {code_acc_r[14:0], serial_bit};
                    end
                    state_nxt = ST_SHIFT;
                end
            end
            ST_SHIFT: begin
                bit_cnt_nxt = bit_cnt_r + 7'h01;
                if (bit_cnt_r == `BIA_READ_BITS - 1)
                    state_nxt = ST_CHECK;
                else
                    state_nxt = ST_SAMPLE;
            end
            ST_CHECK: begin
                // Presence rests on the validation code and on the read not being aborted.
                present_nxt = ~aborted_r && (code_acc_r == VALID_CODE);
                addr_ok_nxt = ~aborted_r && (code_acc_r == VALID_CODE) &&
                              (addr_acc_r[`BIA_FMT_HI:`BIA_FMT_LO] == `BIA_FMT_VALUE);
                bia_nxt     = addr_acc_r;
                done_nxt    = 1'b1;
                state_nxt   = ST_IDLE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_r     <= ST_IDLE;
            bit_cnt_r   <= 7'h00;
            addr_acc_r  <= `BIA_ADDR_RST;
            code_acc_r  <= `BIA_CODE_RST;
            byte_acc_r  <= 8'h00;
            push_r      <= 1'b0;
            push_data_r <= 8'h00;
            aborted_r   <= 1'b0;
            present_r   <= 1'b0;
            addr_ok_r   <= 1'b0;
            done_r      <= 1'b0;
            bia_r       <= `BIA_ADDR_RST;
        end else if (clk_en) begin
            state_r     <= state_nxt;
            bit_cnt_r   <= bit_cnt_nxt;
            addr_acc_r  <= addr_acc_nxt;
            code_acc_r  <= code_acc_nxt;
            byte_acc_r  <= byte_acc_nxt;
            push_r      <= push_nxt;
            push_data_r <= push_data_nxt;
            aborted_r   <= aborted_nxt;
            present_r   <= present_nxt;
            addr_ok_r   <= addr_ok_nxt;
            done_r      <= done_nxt;
            bia_r       <= bia_nxt;
        end
    end

    assign init_busy              = (state_r != ST_IDLE);
    assign init_done              = done_r;
    assign circuit_present        = present_r;
    assign address_ok             = addr_ok_r;
    assign burned_in_node_address = bia_r;

    ////////////////////////////////////////////////////////////////////////////////
    // Address bytes leave through the FIFO; a stalled drain stalls the reader.

    addr_byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH),
        .AW    (3)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (push_r),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_r),
        .out_valid (byte_valid),
        .out_ready (byte_ready),
        .out_data  (byte_data),
        .flush     (init_start && state_r == ST_IDLE)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Ring join: pick the station address or refuse with a node address error.

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            join_done_r <= 1'b0;
            join_err_r  <= 1'b0;
            station_r   <= `BIA_ADDR_RST;
        end else if (clk_en) begin
            join_done_r <= join_req;
            if (join_req) begin
                if (join_addr != `BIA_ADDR_RST) begin
                    join_err_r <= 1'b0;
                    station_r  <= join_addr;
                end else if (done_r && addr_ok_r) begin
                    join_err_r <= 1'b0;
                    station_r  <= bia_r;
                end else begin
                    join_err_r <= 1'b1;
                end
            end
        end
    end

    assign join_done    = join_done_r;
    assign join_error   = join_err_r;
    assign station_addr = station_r;

endmodule

// ==== burned_in_address_reader_map.vh ====
// Constants for the burned-in node address reader.
`ifndef BURNED_IN_ADDRESS_READER_MAP_VH
`define BURNED_IN_ADDRESS_READER_MAP_VH

// Store geometry: 512 words of 4 bits, 9 address lines.
`define BIA_STORE_DEPTH       512
`define BIA_STORE_AW          9
`define BIA_STORE_DW          4

// Shift register width and the part of it that addresses the store.
`define BIA_SHREG_W           8
`define BIA_LOW_ADDR_W        7
`define BIA_SEQ_LEN           127

// Store address line positions.
`define BIA_A_INSERT          8
`define BIA_A_FAULT           7

// Store output column positions within a word.
`define BIA_COL_FEEDBACK      0
`define BIA_COL_ADDRESS       1
`define BIA_COL_SPARE_LO      2
`define BIA_COL_SPARE_HI      3

// Serial layout: 48 address bits first, then the validation code.
`define BIA_ADDR_BITS         48
`define BIA_CODE_BITS         16
`define BIA_READ_BITS         64
`define BIA_ADDR_BYTES        6

// Node address format check on byte 0 (first byte, bits 0 and 1).
`define BIA_FMT_HI            47
`define BIA_FMT_LO            46
`define BIA_FMT_VALUE         2'h1

// Reset values.
`define BIA_ADDR_RST          48'h000000000000
`define BIA_CODE_RST          16'h0000

`endif

// ==== addr_byte_fifo.v ====
// Synchronous FIFO with valid and ready on both sides.
`timescale 1ns/100ps
module addr_byte_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             reset,
    input  wire             clk_en,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    input  wire             flush
);

    reg  [WIDTH-1:0] mem [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr_r;
    reg  [AW-1:0]    rd_ptr_r;
    reg  [AW:0]      count_r;
    wire             push;
    wire             pop;

    assign in_ready  = (count_r != DEPTH[AW:0]);
    assign out_valid = (count_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_ptr_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    function [AW-1:0] ptr_inc;
        input [AW-1:0] p;
        begin
            if (p == DEPTH[AW-1:0] - {{(AW-1){1'b0}}, 1'b1})
                ptr_inc = {AW{1'b0}};
            else
                ptr_inc = p + {{(AW-1){1'b0}}, 1'b1};
        end
    endfunction

    always @(posedge ref_clk) begin
        if (clk_en && push)
            mem[wr_ptr_r] <= in_data;
    end

    always @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r  <= {(AW+1){1'b0}};
        end else if (clk_en) begin
            if (flush) begin
                wr_ptr_r <= {AW{1'b0}};
                rd_ptr_r <= {AW{1'b0}};
                count_r  <= {(AW+1){1'b0}};
            end else begin
                if (push)
                    wr_ptr_r <= ptr_inc(wr_ptr_r);
                if (pop)
                    rd_ptr_r <= ptr_inc(rd_ptr_r);
                if (push && !pop)
                    count_r <= count_r + {{AW{1'b0}}, 1'b1};
                else if (pop && !push)
                    count_r <= count_r - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

// ==== burned_in_address_reader_monitor.sv ====
// Concurrent checks on the ports of the burned-in address reader.
`timescale 1ns/100ps
module burned_in_address_reader_monitor (
    input logic        ref_clk,
    input logic        reset,
    input logic        clk_en,
    input logic        ring_insert_control,
    input logic        wire_fault_line,
    input logic        handler_shift_clk,
    input logic        fault_to_handler,
    input logic        init_start,
    input logic        init_busy,
    input logic        init_done,
    input logic        circuit_present,
    input logic        address_ok,
    input logic [47:0] burned_in_node_address,
    input logic        byte_valid,
    input logic        byte_ready,
    input logic [7:0]  byte_data,
    input logic        join_req,
    input logic [47:0] join_addr,
    input logic        join_done,
    input logic        join_error,
    input logic [47:0] station_addr
);
    default clocking mon_cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    sequence read_taken;
        clk_en && init_start && !init_busy;
    endsequence
    sequence read_ends;
        !init_done && init_busy ##[1:1000] init_done;
    endsequence

    read_bound_a: assert property (read_taken |=> read_ends)
        else $error("read did not complete in time");
    busy_ignore_a: assert property (clk_en && init_start && init_busy |=> init_busy)
        else $error("start taken while busy");
    join_pulse_a: assert property (clk_en && join_req |=> join_done)
        else $error("join not answered next cycle");
    join_cause_a: assert property (join_done |-> $past(join_req))
        else $error("join done without request");
    bia_select_a: assert property (clk_en && join_req && join_addr == 48'h0
        && address_ok |=> !join_error && station_addr == $past(burned_in_node_address))
        else $error("zero join did not take stored address");
    no_bia_a: assert property (clk_en && join_req && join_addr == 48'h0 && !address_ok
        |=> join_error)
        else $error("zero join without good address did not fail");
    given_addr_a: assert property (clk_en && join_req && join_addr != 48'h0
        |=> !join_error && station_addr == $past(join_addr))
        else $error("given join address not used");
    format_ok_a: assert property (address_ok
        |-> circuit_present && burned_in_node_address[47:46] == 2'h1)
        else $error("address accepted with bad format bits");
    pass_fault_a: assert property ((clk_en && !ring_insert_control && $stable(wire_fault_line))[*7]
        |-> fault_to_handler == wire_fault_line)
        else $error("fault level not passed through");
    fifo_hold_a: assert property (clk_en && byte_valid && !byte_ready && !init_start
        |=> byte_valid && $stable(byte_data))
        else $error("stalled byte changed");
endmodule

bind burned_in_address_reader burned_in_address_reader_monitor mon (
    .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
    .ring_insert_control(ring_insert_control), .wire_fault_line(wire_fault_line),
    .handler_shift_clk(handler_shift_clk), .fault_to_handler(fault_to_handler),
    .init_start(init_start), .init_busy(init_busy), .init_done(init_done),
    .circuit_present(circuit_present), .address_ok(address_ok),
    .burned_in_node_address(burned_in_node_address), .byte_valid(byte_valid),
    .byte_ready(byte_ready), .byte_data(byte_data), .join_req(join_req),
    .join_addr(join_addr), .join_done(join_done), .join_error(join_error),
    .station_addr(station_addr));

// ==== ring_handler_model.sv ====
// Behavioural protocol handler and ring interface as seen by the reader.
`timescale 1ns/100ps
module ring_handler_model (
    input  logic        ref_clk,
    input  logic        fault_to_handler,
    output logic        ring_insert_control,
    output logic        wire_fault_line,
    output logic        handler_shift_clk,
    output logic [63:0] seen_bits
);
    initial begin
        ring_insert_control = 1'b1;
        wire_fault_line     = 1'b0;
        handler_shift_clk   = 1'b0;
        seen_bits           = 64'h0;
    end

    task automatic set_pins(input logic insert, input logic fault);
        @(negedge ref_clk);
        ring_insert_control <= insert;
        wire_fault_line     <= fault;
    endtask

    // Takes one bit through the inverting fault input, then steps the register.
    // The fault level is toggled each step since it must not matter in the upper bank.
    task automatic walk(input int n);
        for (int k = 0; k < n; k++) begin
            seen_bits = {seen_bits[62:0], ~fault_to_handler};
            wire_fault_line   <= ~wire_fault_line;
            handler_shift_clk <= 1'b1;
            repeat (3) @(negedge ref_clk);
            handler_shift_clk <= 1'b0;
            repeat (5) @(negedge ref_clk);
        end
    endtask
endmodule

// ==== burned_in_address_reader_test.sv ====
// Self-checking bench for the burned-in address reader.
`timescale 1ns/100ps
module burned_in_address_reader_test;
    localparam logic [47:0] BURNED_IN_NODE_ADDRESS  = 48'h400000000001;
    localparam logic [47:0] BAD  = 48'hC00000000001;
    localparam logic [15:0] CODE = 16'hA55A;
    logic        ref_clk, reset, clk_en, init_start, byte_ready, join_req;
    logic [47:0] join_addr;
    logic        ring_insert_control, wire_fault_line, handler_shift_clk;
    logic [63:0] seen_bits;
    logic        fault_to_handler, init_busy, init_done, circuit_present, address_ok;
    logic [47:0] burned_in_node_address, station_addr;
    logic        byte_valid, join_done, join_error, b_present, b_ok, b_err;
    logic [7:0]  byte_data;
    int          miscompares = 0;
    int          samples_checked = 0;
    logic [47:0] row_addr [4] = '{48'h0, 48'h123456789ABC, 48'hFFFFFFFFFFFF, 48'h0};
    logic [47:0] row_station [4] = '{BURNED_IN_NODE_ADDRESS, 48'h123456789ABC, 48'hFFFFFFFFFFFF, BURNED_IN_NODE_ADDRESS};
    logic        row_berr [4] = '{1'b1, 1'b0, 1'b0, 1'b1};

    burned_in_address_reader #(.BIA_VALUE(BURNED_IN_NODE_ADDRESS), .VALID_CODE(CODE), .FIFO_DEPTH(8)) DUT (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .ring_insert_control(ring_insert_control), .wire_fault_line(wire_fault_line),
        .handler_shift_clk(handler_shift_clk), .fault_to_handler(fault_to_handler),
        .init_start(init_start), .init_busy(init_busy), .init_done(init_done),
        .circuit_present(circuit_present), .address_ok(address_ok),
        .burned_in_node_address(burned_in_node_address), .byte_valid(byte_valid),
        .byte_ready(byte_ready), .byte_data(byte_data), .join_req(join_req),
        .join_addr(join_addr), .join_done(join_done), .join_error(join_error),
        .station_addr(station_addr));
    burned_in_address_reader #(.BIA_VALUE(BAD), .VALID_CODE(CODE), .FIFO_DEPTH(8)) bad_dut (
        .ref_clk(ref_clk), .reset(reset), .clk_en(clk_en),
        .ring_insert_control(ring_insert_control), .wire_fault_line(wire_fault_line),
        .handler_shift_clk(handler_shift_clk), .fault_to_handler(),
        .init_start(init_start), .init_busy(), .init_done(),
        .circuit_present(b_present), .address_ok(b_ok), .burned_in_node_address(),
        .byte_valid(), .byte_ready(byte_ready), .byte_data(), .join_req(join_req),
        .join_addr(join_addr), .join_done(), .join_error(b_err), .station_addr());
    ring_handler_model hm (
        .ref_clk(ref_clk), .fault_to_handler(fault_to_handler),
        .ring_insert_control(ring_insert_control), .wire_fault_line(wire_fault_line),
        .handler_shift_clk(handler_shift_clk), .seen_bits(seen_bits));

    always #10 ref_clk = ~ref_clk;

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_flag(input logic got, input logic exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_word(input logic [63:0] got, input logic [63:0] exp);
        samples_checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_of_test;
        if (miscompares == 0 && samples_checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // A second start is given while busy and must be ignored.
    task automatic run_read(input int abort_at);
        int n;
        n = 0;
        init_start <= 1'b1;
        @(negedge ref_clk);
        init_start <= 1'b0;
        @(negedge ref_clk);
        while (init_done !== 1'b1 && n < 2000) begin
            init_start <= (n == 5);
            if (n == abort_at) hm.set_pins(1'b0, 1'b0);
            else @(negedge ref_clk);
            n++;
        end
        init_start <= 1'b0;
        check_flag(init_done, 1'b1);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        clk_en = 1'b1;
        init_start = 1'b0;
        byte_ready = 1'b0;
        join_req = 1'b0;
        join_addr = 48'h0;
        repeat (12) @(negedge ref_clk);
        reset <= 1'b0;
        repeat (4) @(negedge ref_clk);
        run_read(-1);
        check_flag(circuit_present, 1'b1);
        check_flag(address_ok, 1'b1);
        check_word(burned_in_node_address, BURNED_IN_NODE_ADDRESS);
        check_flag(b_present, 1'b1);
        check_flag(b_ok, 1'b0);
        for (int i = 0; i < 6; i++) begin
            check_flag(byte_valid, 1'b1);
            check_word(byte_data, BURNED_IN_NODE_ADDRESS[47-8*i -: 8]);
            byte_ready <= 1'b1;
            @(negedge ref_clk);
            byte_ready <= 1'b0;
            @(negedge ref_clk);
        end
        check_flag(byte_valid, 1'b0);
        for (int r = 0; r < 4; r++) begin
            join_req <= 1'b1;
            join_addr <= row_addr[r];
            @(negedge ref_clk);
            check_flag(join_done, 1'b1);
            check_flag(join_error, 1'b0);
            check_word(station_addr, row_station[r]);
            check_flag(b_err, row_berr[r]);
        end
        join_req <= 1'b0;
        join_addr <= 48'h0;
        reset <= 1'b1;
        repeat (2) @(negedge ref_clk);
        check_flag(init_done, 1'b0);
        check_flag(byte_valid, 1'b0);
        check_word(station_addr, 64'h0);
        reset <= 1'b0;
        repeat (10) @(negedge ref_clk);
        hm.walk(64);
        check_word(seen_bits, {BURNED_IN_NODE_ADDRESS, CODE});
        for (int v = 0; v < 2; v++) begin
            hm.set_pins(1'b0, v[0]);
            repeat (8) @(negedge ref_clk);
            check_flag(fault_to_handler, v[0]);
        end
        hm.set_pins(1'b1, 1'b0);
        repeat (4) @(negedge ref_clk);
        run_read(40);
        check_flag(circuit_present, 1'b0);
        hm.set_pins(1'b1, 1'b0);
        join_req <= 1'b1;
        @(negedge ref_clk);
        join_req <= 1'b0;
        check_flag(join_error, 1'b1);
        repeat (4) @(negedge ref_clk);
        end_of_test;
    end

    initial begin
        repeat (20000) @(posedge ref_clk);
        miscompares++;
        end_of_test;
    end
endmodule
